// ---- pkg/tape_ctl_pkg.sv ----
// Shared constants and types for the tape reader stop and punch control
`default_nettype none
package tape_ctl_pkg;
    // Clock rate in kHz, so that msec times convert by one product
    localparam int CLK_KHZ = 20000;
    localparam int FN_INHIBIT_MS = 70; // Function request hold-off
    localparam int WINDOW_MS = 10; // Second sync must fall inside this
    localparam int GATE_MS = 4; // Perforation gate length
    localparam int FN_INHIBIT_CYC = FN_INHIBIT_MS * CLK_KHZ;
    localparam int WINDOW_CYC = WINDOW_MS * CLK_KHZ;
    localparam int GATE_CYC = GATE_MS * CLK_KHZ;
    localparam int TMR_W = 21; // Holds the longest count
    localparam logic [TMR_W-1:0] TMR_ONE = 21'h000001;
    localparam logic [TMR_W-1:0] TMR_ZERO = 21'h000000;

    // Function word and output data widths
    localparam int FW_W = 8;
    localparam int OD_W = 8;
    localparam logic [OD_W-1:0] OUT_REG_RST = 8'h00;
    // Perforator on and off codes (octal 005/015, 001/011)
    localparam logic [FW_W-1:0] FW_PUNCH_ON_A = 8'h05;
    localparam logic [FW_W-1:0] FW_PUNCH_ON_B = 8'h0d;
    localparam logic [FW_W-1:0] FW_PUNCH_OFF_A = 8'h01;
    localparam logic [FW_W-1:0] FW_PUNCH_OFF_B = 8'h09;

    // Bit positions in the synchronised control vector
    localparam int SI_HEAD = 0;
    localparam int SI_ARM_CANCEL = 1;
    localparam int SI_RD_STOP = 2;
    localparam int SI_GCLR = 3;
    localparam int SI_FN_ACK = 4;
    localparam int SI_IN_ACK = 5;
    localparam int SI_OUT_ACK = 6;
    localparam int SI_PSYNC = 7;
    localparam int SI_SPROCKET = 8;
    localparam int SI_RD_START = 9;
    localparam int SI_ARM_SET = 10;
    localparam int SI_AUTO_SEL = 11;
    localparam int SI_KEYS_RDY = 12;
    localparam int SI_KBD_START = 13;
    localparam int SI_FN_NEED = 14;
    localparam int N_SYNC = 15;

    // Data and feed-hole strobe toward the perforator
    typedef struct packed {
        logic [OD_W-1:0] data;
        logic feed_hole;
    } perf_drive_t;

    // Perforator handshake states
    typedef enum logic [5:0] {
        P_IDLE = 6'h01,
        P_ARM = 6'h02,
        P_WIN = 6'h04,
        P_REQ = 6'h08,
        P_PEND = 6'h10,
        P_GATE = 6'h20
    } perf_state_t;
endpackage : tape_ctl_pkg
`default_nettype wire

// ---- rtl/edge_sync.sv ----
// Two-stage synchroniser per bit with a rising-edge pulse
`default_nettype none
module edge_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [W-1:0] raw,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    // Stage one is read only by stage two
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // Metastability chain, then one history flop for the edge
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    s1_q[i] <= 1'b0;
                    s2_q[i] <= 1'b0;
                    s3_q[i] <= 1'b0;
                end else begin
                    s1_q[i] <= raw[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                end
            end
            assign level[i] = s2_q[i];
            // One pulse per rising edge, however long the input stays high
            assign rise[i] = s2_q[i] & ~s3_q[i];
        end
    endgenerate
endmodule : edge_sync
`default_nettype wire

// ---- rtl/ms_timer.sv ----
// Loadable down-counter for the millisecond intervals
`default_nettype none
module ms_timer
    import tape_ctl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic [TMR_W-1:0] load,
    output logic busy,
    output logic done
);
    logic [TMR_W-1:0] cnt_q; // Cycles left

    // A start restarts the interval even when already running
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= TMR_ZERO;
        end else if (start) begin
            cnt_q <= load;
        end else if (cnt_q != TMR_ZERO) begin
            cnt_q <= cnt_q - TMR_ONE;
        end
    end

    assign busy = (cnt_q != TMR_ZERO);
    // Pulses in the last counted cycle
    assign done = (cnt_q == TMR_ONE) && !start;
endmodule : ms_timer
`default_nettype wire

// ---- rtl/tape_ctl.sv ----
// Paper tape reader stop paths and on-line perforator handshake
// Function
// - Head lifted clears arm after 70 msec quiet
// - Head lifted blocks reader load enable
// - Head lifted or ready clear stops tape
// - Clear arm with automatic read blocks request
// - Arm cancel button only clears the arm
// - Reader stop drops selects, arm, lockout, ready
// - Reader stop clears ready, load, motor
// - Ready flag clear blocks input requests
// - Idle reader and keys clear holding register
// - Global clear inhibits function requests 70 msec
// - Global clear clears arm at inhibit end
// - Global clear sets reader request permit
// - Global clear also does reader stop actions, except the immediate arm clear
// - Codes 005/015 start perforator motor
// - Second sync within 10 msec sets ready
// - Perforator ready raises output word request
// - Output ack loads register, drops request
// - Next sync clears pending, opens 4 msec gate
// - No output request while gate open
// - Function ack inhibits function request 70 msec
// - Gate close clears register, requests again
`default_nettype none
module tape_ctl
    import tape_ctl_pkg::*;
#(
    parameter int FN_INHIBIT_CYC_P = FN_INHIBIT_CYC,
    parameter int WINDOW_CYC_P = WINDOW_CYC,
    parameter int GATE_CYC_P = GATE_CYC
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic head_lifted,
    input wire logic arm_cancel_button,
    input wire logic reader_stop_button,
    input wire logic global_clear,
    input wire logic function_word_ack,
    input wire logic [FW_W-1:0] function_word,
    input wire logic function_word_needed,
    input wire logic input_word_ack,
    input wire logic output_word_ack,
    input wire logic [OD_W-1:0] output_lines,
    input wire logic perforator_sync,
    input wire logic reader_sprocket,
    input wire logic reader_start,
    input wire logic arm_set_button,
    input wire logic auto_read_select,
    input wire logic keys_word_ready,
    input wire logic keyboard_start,
    output logic auto_read_arm,
    output logic reader_select,
    output logic keyboard_select,
    output logic keyboard_read_lockout,
    output logic reader_ready_flag,
    output logic reader_ready_clear,
    output logic reader_load_enable,
    output logic reader_motor_on,
    output logic tape_step_cmd,
    output logic reader_request_permit,
    output logic input_word_request,
    output logic input_holding_clear,
    output logic function_word_request,
    output logic perforator_active,
    output logic perforator_ready_flag,
    output logic output_word_request,
    output logic frame_pending_flag,
    output perf_drive_t perf_drive
);
    // Synchronised pins: levels and one-cycle rising edges
    logic [N_SYNC-1:0] pin_raw;
    logic [N_SYNC-1:0] lvl;
    logic [N_SYNC-1:0] rise;
    logic [FW_W+OD_W-1:0] word_lvl; // Function word and output lines
    logic [FW_W-1:0] fw_s;
    logic [OD_W-1:0] od_s;

    assign pin_raw[SI_HEAD] = head_lifted;
    assign pin_raw[SI_ARM_CANCEL] = arm_cancel_button;
    assign pin_raw[SI_RD_STOP] = reader_stop_button;
    assign pin_raw[SI_GCLR] = global_clear;
    assign pin_raw[SI_FN_ACK] = function_word_ack;
    assign pin_raw[SI_IN_ACK] = input_word_ack;
    assign pin_raw[SI_OUT_ACK] = output_word_ack;
    assign pin_raw[SI_PSYNC] = perforator_sync;
    assign pin_raw[SI_SPROCKET] = reader_sprocket;
    assign pin_raw[SI_RD_START] = reader_start;
    assign pin_raw[SI_ARM_SET] = arm_set_button;
    assign pin_raw[SI_AUTO_SEL] = auto_read_select;
    assign pin_raw[SI_KEYS_RDY] = keys_word_ready;
    assign pin_raw[SI_KBD_START] = keyboard_start;
    assign pin_raw[SI_FN_NEED] = function_word_needed;

    // Every pin crosses two flops before use edges give single events
    edge_sync #(.W(N_SYNC)) u_ctl_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .raw(pin_raw),
        .level(lvl),
        .rise(rise)
    );

    // Data words take the same delay as their acknowledge, so the edge sees them settled
    edge_sync #(.W(FW_W + OD_W)) u_word_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .raw({function_word, output_lines}),
        .level(word_lvl),
        .rise()
    );
    assign fw_s = word_lvl[FW_W+OD_W-1:OD_W];
    assign od_s = word_lvl[OD_W-1:0];

    // Decoded events
    logic head; // Head raised, level
    logic gc_rise; // Global clear event
    logic stop_evt; // Reader stop from button or global clear
    logic punch_on;
    logic punch_off;
    assign head = lvl[SI_HEAD];
    assign gc_rise = rise[SI_GCLR];
    assign stop_evt = rise[SI_RD_STOP] | gc_rise;
    assign punch_on = rise[SI_FN_ACK] & ((fw_s == FW_PUNCH_ON_A) | (fw_s == FW_PUNCH_ON_B));
    assign punch_off = rise[SI_FN_ACK] & ((fw_s == FW_PUNCH_OFF_A) | (fw_s == FW_PUNCH_OFF_B));

    // Function request hold-off, restarted by each ack or global clear
    logic fn_inh_busy;
    logic fn_inh_done;
    ms_timer u_fn_inhibit (
        .core_clk(core_clk),
        .rstn(rstn),
        .start(rise[SI_FN_ACK] | gc_rise),
        .load(TMR_W'(FN_INHIBIT_CYC_P)),
        .busy(fn_inh_busy),
        .done(fn_inh_done)
    );

    // Function request follows demand, masked by the hold-off
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            function_word_request <= 1'b0;
        end else begin
            function_word_request <= lvl[SI_FN_NEED] & ~fn_inh_busy & ~gc_rise;
        end
    end

    // Arm clear requested by global clear, applied when the hold-off ends
    logic arm_clr_pend_q;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            arm_clr_pend_q <= 1'b0;
        end else if (gc_rise) begin
            arm_clr_pend_q <= 1'b1;
        end else if (fn_inh_done) begin
            arm_clr_pend_q <= 1'b0;
        end
    end

    // Automatic read arm: every clear outranks the operator's set
    logic arm_d;
    always_comb begin
        arm_d = auto_read_arm;
        if (rise[SI_ARM_SET]) begin
            arm_d = 1'b1;
        end
        if (head && !fn_inh_busy) begin
            arm_d = 1'b0;
        end
        if (rise[SI_ARM_CANCEL] || rise[SI_RD_STOP]) begin
            arm_d = 1'b0;
        end
        if (arm_clr_pend_q && fn_inh_done) begin
            arm_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            auto_read_arm <= 1'b0;
        end else begin
            auto_read_arm <= arm_d;
        end
    end

    // Reader and keyboard interlock gates; stop wins over a start
    logic rsel_d;
    logic ready_d;
    assign rsel_d = ~stop_evt & (reader_select | rise[SI_RD_START]);
    assign ready_d = ~stop_evt & (reader_ready_flag | rise[SI_RD_START]);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reader_select <= 1'b0;
            keyboard_select <= 1'b0;
            keyboard_read_lockout <= 1'b0;
            reader_ready_flag <= 1'b0;
            reader_motor_on <= 1'b0;
            reader_ready_clear <= 1'b0;
        end else begin
            reader_select <= rsel_d;
            keyboard_select <= ~stop_evt & (keyboard_select | rise[SI_KBD_START]);
            // Keyboard stays locked out only while the reader owns input
            keyboard_read_lockout <= rsel_d;
            reader_ready_flag <= ready_d;
            reader_motor_on <= ~stop_evt & (reader_motor_on | rise[SI_RD_START]);
            reader_ready_clear <= stop_evt;
        end
    end

    // Request permit: cleared by input ack, set again by the sprocket
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reader_request_permit <= 1'b1;
        end else if (gc_rise || rise[SI_SPROCKET]) begin
            reader_request_permit <= 1'b1;
        end else if (rise[SI_IN_ACK]) begin
            reader_request_permit <= 1'b0;
        end
    end

    // Reader data path and handshake toward the computer
    logic in_req_d;
    always_comb begin
        in_req_d = ready_d & reader_request_permit & ~head & ~stop_evt;
        if (lvl[SI_AUTO_SEL] && !arm_d) begin
            in_req_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reader_load_enable <= 1'b0;
            tape_step_cmd <= 1'b0;
            input_word_request <= 1'b0;
            input_holding_clear <= 1'b1;
        end else begin
            reader_load_enable <= ready_d & ~head;
            // Tape advances after an ack until the next sprocket
            tape_step_cmd <= ready_d & ~head & ~reader_request_permit;
            input_word_request <= in_req_d;
            input_holding_clear <= ~ready_d & ~lvl[SI_KEYS_RDY] & ~lvl[SI_IN_ACK];
        end
    end

    // Perforator sequencer; one timer serves the window and the gate
    perf_state_t pst_q;
    perf_state_t pst_d;
    logic ptmr_start;
    logic [TMR_W-1:0] ptmr_load;
    logic ptmr_busy;
    logic ptmr_done;
    logic [OD_W-1:0] oreg_q; // Output register
    logic [OD_W-1:0] oreg_d;
    logic pready_d;

    ms_timer u_perf_timer (
        .core_clk(core_clk),
        .rstn(rstn),
        .start(ptmr_start),
        .load(ptmr_load),
        .busy(ptmr_busy),
        .done(ptmr_done)
    );

    // Next state; deactivation and global clear abort any stage
    always_comb begin
        pst_d = pst_q;
        ptmr_start = 1'b0;
        ptmr_load = TMR_W'(WINDOW_CYC_P);
        oreg_d = oreg_q;
        pready_d = perforator_ready_flag;
        unique case (pst_q)
            P_IDLE: begin
                if (punch_on) begin
                    pst_d = P_ARM;
                end
            end
            P_ARM: begin
                if (rise[SI_PSYNC]) begin
                    ptmr_start = 1'b1;
                    pst_d = P_WIN;
                end
            end
            P_WIN: begin
                if (rise[SI_PSYNC] && ptmr_busy) begin
                    pready_d = 1'b1;
                    pst_d = P_REQ;
                end else if (!ptmr_busy) begin
                    // Too slow: window lapsed, back to wait; the next sync counts as a new first one
                    pst_d = P_ARM;
                end
            end
            P_REQ: begin
                if (rise[SI_OUT_ACK]) begin
                    oreg_d = od_s;
                    pst_d = P_PEND;
                end
            end
            P_PEND: begin
                if (rise[SI_PSYNC]) begin
                    ptmr_start = 1'b1;
                    ptmr_load = TMR_W'(GATE_CYC_P);
                    pst_d = P_GATE;
                end
            end
            P_GATE: begin
                if (ptmr_done) begin
                    oreg_d = OUT_REG_RST;
                    pst_d = P_REQ;
                end
            end
            default: begin
                pst_d = P_IDLE;
            end
        endcase
        if (punch_off || gc_rise) begin
            pst_d = P_IDLE;
            pready_d = 1'b0;
            oreg_d = OUT_REG_RST;
        end
    end

    // State and output register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pst_q <= P_IDLE;
            oreg_q <= OUT_REG_RST;
        end else begin
            pst_q <= pst_d;
            oreg_q <= oreg_d;
        end
    end

    // Perforator outputs, registered from next state
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            perforator_active <= 1'b0;
            perforator_ready_flag <= 1'b0;
            output_word_request <= 1'b0;
            frame_pending_flag <= 1'b0;
            perf_drive <= '{data: OUT_REG_RST, feed_hole: 1'b0};
        end else begin
            perforator_active <= (pst_d != P_IDLE);
            perforator_ready_flag <= pready_d;
            output_word_request <= (pst_d == P_REQ);
            frame_pending_flag <= (pst_d == P_PEND);
            // Data only reaches the pins while the gate is open
            perf_drive.feed_hole <= (pst_d == P_GATE);
            perf_drive.data <= (pst_d == P_GATE) ? oreg_d : OUT_REG_RST;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_head_load;
        head |=> !reader_load_enable;
    endproperty
    a_head_load: assert property (p_head_load) else $error("load enable with head up");

    property p_step_stop;
        (head || !ready_d) |=> !tape_step_cmd;
    endproperty
    a_step_stop: assert property (p_step_stop) else $error("tape step not withdrawn");

    property p_auto_block;
        (lvl[SI_AUTO_SEL] && !arm_d) |=> !input_word_request;
    endproperty
    a_auto_block: assert property (p_auto_block) else $error("request with arm clear");

    property p_stop;
        rise[SI_RD_STOP] |=> !reader_ready_flag && !reader_motor_on && !reader_select
            && !auto_read_arm && reader_ready_clear && !input_word_request;
    endproperty
    a_stop: assert property (p_stop) else $error("reader stop incomplete");

    property p_fn_inhibit;
        rise[SI_FN_ACK] |=> ##1 !function_word_request [*8];
    endproperty
    a_fn_inhibit: assert property (p_fn_inhibit) else $error("function request too soon");

    property p_gc_permit;
        gc_rise |=> reader_request_permit && !reader_ready_flag;
    endproperty
    a_gc_permit: assert property (p_gc_permit) else $error("global clear permit");

    property p_punch_on;
        (punch_on && !gc_rise && pst_q == P_IDLE) |=> perforator_active && !output_word_request;
    endproperty
    a_punch_on: assert property (p_punch_on) else $error("perforator not started");

    sequence s_ack_taken;
        output_word_request && rise[SI_OUT_ACK] && !punch_off && !gc_rise;
    endsequence
    sequence s_pending;
        !output_word_request && frame_pending_flag && !perf_drive.feed_hole;
    endsequence
    property p_ack_load;
        s_ack_taken |=> s_pending;
    endproperty
    a_ack_load: assert property (p_ack_load) else $error("output ack not taken");

    property p_gate_no_req;
        perf_drive.feed_hole |-> !output_word_request && !frame_pending_flag;
    endproperty
    a_gate_no_req: assert property (p_gate_no_req) else $error("request during gate");

    property p_ready_req;
        $rose(perforator_ready_flag) |-> output_word_request;
    endproperty
    a_ready_req: assert property (p_ready_req) else $error("no request on ready");
endmodule : tape_ctl
`default_nettype wire

// ---- verif/host_model.sv ----
// Host computer model: function words and output data acknowledges
`default_nettype none
module host_model
    import tape_ctl_pkg::*;
(
    input wire logic core_clk,
    input wire logic fw_go,
    input wire logic [FW_W-1:0] fw_code,
    input wire logic od_en,
    input wire logic [OD_W-1:0] od_word,
    input wire logic output_word_request,
    output logic function_word_ack,
    output logic [FW_W-1:0] function_word,
    output logic output_word_ack,
    output logic [OD_W-1:0] output_lines
);
    timeunit 1ns;
    timeprecision 1ns;
    // Word set up four cycles before the ack, garbled once released
    initial begin
        function_word_ack = 1'b0;
        function_word = 8'h00;
        forever begin
            @(posedge core_clk);
            if (fw_go) begin
                function_word <= fw_code;
                repeat (4) @(posedge core_clk);
                function_word_ack <= 1'b1;
                repeat (4) @(posedge core_clk);
                function_word_ack <= 1'b0;
                repeat (2) @(posedge core_clk);
                function_word <= ~fw_code;
            end
        end
    end
    // Answers a request only while enabled, so the bench can stall
    initial begin
        output_word_ack = 1'b0;
        output_lines = 8'h00;
        forever begin
            @(posedge core_clk);
            if (od_en && output_word_request) begin
                output_lines <= od_word;
                repeat (4) @(posedge core_clk);
                output_word_ack <= 1'b1;
                repeat (4) @(posedge core_clk);
                output_word_ack <= 1'b0;
                // Wait out the request drop so one request gets one ack
                repeat (8) @(posedge core_clk);
                output_lines <= ~od_word;
            end
        end
    end
endmodule : host_model
`default_nettype wire

// ---- verif/tape_ctl_test.sv ----
// Self-checking bench for the reader stop and perforator control
`default_nettype none
module tape_ctl_test
    import tape_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Shortened intervals keep the run brief
    localparam int FN = 40;
    localparam int WIN = 30;
    localparam int GT = 16;
    localparam logic [7:0] STIM [4] = '{8'h43, 8'h04, 8'h02, 8'h08};
    localparam logic [5:0] EXPV [4] = '{6'h3f, 6'h2e, 6'h3f, 6'h00};
    localparam logic [7:0] ON [2] = '{FW_PUNCH_ON_A, FW_PUNCH_ON_B};
    localparam logic [7:0] OFF [2] = '{FW_PUNCH_OFF_A, FW_PUNCH_OFF_B};
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic head_lifted = 1'b0;
    logic auto_read_select = 1'b1;
    logic function_word_needed = 1'b1;
    logic input_word_ack = 1'b0;
    logic keys_word_ready = 1'b0;
    logic fw_go = 1'b0;
    logic od_en = 1'b0;
    logic [7:0] ev = 8'h00; // Event pins, one bit each
    logic [FW_W-1:0] fw_code = 8'h00;
    logic [OD_W-1:0] od_word = 8'h00;
    logic reader_start, arm_set_button, arm_cancel_button, reader_stop_button;
    logic global_clear, perforator_sync, keyboard_start, reader_sprocket;
    logic function_word_ack, output_word_ack;
    logic [FW_W-1:0] function_word;
    logic [OD_W-1:0] output_lines;
    logic auto_read_arm, reader_select, keyboard_select, keyboard_read_lockout;
    logic reader_ready_flag, reader_ready_clear, reader_load_enable;
    logic reader_motor_on, tape_step_cmd, reader_request_permit;
    logic input_word_request, input_holding_clear, function_word_request;
    logic perforator_active, perforator_ready_flag, output_word_request;
    logic frame_pending_flag;
    perf_drive_t perf_drive;
    int err_total = 0;
    int checks = 0;
    assign {reader_sprocket, keyboard_start, perforator_sync, global_clear,
        reader_stop_button, arm_cancel_button, arm_set_button, reader_start} = ev;
    // Free-running 20 MHz clock
    always #25 core_clk = ~core_clk;
    tape_ctl #(.FN_INHIBIT_CYC_P(FN), .WINDOW_CYC_P(WIN), .GATE_CYC_P(GT)) DUT (
        .core_clk, .rstn, .head_lifted, .arm_cancel_button, .reader_stop_button,
        .global_clear, .function_word_ack, .function_word, .function_word_needed,
        .input_word_ack, .output_word_ack, .output_lines, .perforator_sync,
        .reader_sprocket, .reader_start, .arm_set_button, .auto_read_select,
        .keys_word_ready, .keyboard_start, .auto_read_arm, .reader_select,
        .keyboard_select, .keyboard_read_lockout, .reader_ready_flag,
        .reader_ready_clear, .reader_load_enable, .reader_motor_on, .tape_step_cmd,
        .reader_request_permit, .input_word_request, .input_holding_clear,
        .function_word_request, .perforator_active, .perforator_ready_flag,
        .output_word_request, .frame_pending_flag, .perf_drive);
    host_model host (.core_clk, .fw_go, .fw_code, .od_en, .od_word,
        .output_word_request, .function_word_ack, .function_word,
        .output_word_ack, .output_lines);
    // Compare one value, count it, report a miss
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    // Pin high four cycles, then low four, so each event is seen once
    task automatic pulse(input logic [7:0] m);
        ev <= m;
        cyc(4);
        ev <= 8'h00;
        cyc(4);
    endtask : pulse
    // Ask the host model for one function word
    task automatic fw(input logic [7:0] c);
        fw_code <= c;
        fw_go <= 1'b1;
        cyc(1);
        fw_go <= 1'b0;
        cyc(16);
    endtask : fw
    task automatic finish_test;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    // Main sequence
    initial begin
        cyc(8);
        rstn <= 1'b1;
        cyc(2);
        // Arm and reader vector after each stimulus row
        for (int r = 0; r < 4; r++) begin
            pulse(STIM[r]);
            check("kbd_arm_sel_rdy_motor_req", {keyboard_select, auto_read_arm, reader_select,
                reader_ready_flag, reader_motor_on, input_word_request}, EXPV[r]);
        end
        check("lockout", keyboard_read_lockout, 0);
        check("holding_clear", input_holding_clear, 1);
        // Arm clear blocks the request only while automatic read is selected
        pulse(8'h05);
        check("input_word_request", input_word_request, 0);
        auto_read_select <= 1'b0;
        cyc(4);
        check("input_word_request", input_word_request, 1);
        input_word_ack <= 1'b1;
        cyc(5);
        check("tape_step_cmd", tape_step_cmd, 1);
        input_word_ack <= 1'b0;
        auto_read_select <= 1'b1;
        pulse(8'h02);
        head_lifted <= 1'b1;
        cyc(6);
        check("auto_read_arm", auto_read_arm, 0);
        check("reader_load_enable", reader_load_enable, 0);
        check("tape_step_cmd", tape_step_cmd, 0);
        head_lifted <= 1'b0;
        pulse(8'h08);
        // Global clear: inhibit, permit, stop, late arm clear
        pulse(8'h03);
        pulse(8'h10);
        check("function_word_request", function_word_request, 0);
        check("permit", reader_request_permit, 1);
        check("reader_motor_on", reader_motor_on, 0);
        check("auto_read_arm", auto_read_arm, 1);
        cyc(FN);
        check("function_word_request", function_word_request, 1);
        check("auto_read_arm", auto_read_arm, 0);
        // Perforator cycle for each on and off code
        for (int i = 0; i < 2; i++) begin
            od_word <= (i == 0) ? 8'ha5 : 8'h3c;
            fw(ON[i]);
            check("function_word_request", function_word_request, 0);
            check("perforator_active", perforator_active, 1);
            // Second pass lets the window lapse first
            if (i == 1) begin
                pulse(8'h20);
                cyc(WIN + 8);
            end
            pulse(8'h20);
            check("perforator_ready_flag", perforator_ready_flag, 0);
            pulse(8'h20);
            check("perforator_ready_flag", perforator_ready_flag, 1);
            check("output_word_request", output_word_request, 1);
            od_en <= 1'b1;
            cyc(12);
            od_en <= 1'b0;
            check("output_word_request", output_word_request, 0);
            check("frame_pending_flag", frame_pending_flag, 1);
            pulse(8'h20);
            check("frame_pending_flag", frame_pending_flag, 0);
            check("perf_drive", perf_drive, {od_word, 1'b1});
            check("output_word_request", output_word_request, 0);
            cyc(GT);
            check("perf_drive", perf_drive, {8'h00, 1'b0});
            check("output_word_request", output_word_request, 1);
            fw(OFF[i]);
            check("perforator_active", perforator_active, 0);
        end
        // Second reset at the end of the run
        rstn <= 1'b0;
        cyc(2);
        check("permit", reader_request_permit, 1);
        check("holding_clear", input_holding_clear, 1);
        check("output_word_request", output_word_request, 0);
        rstn <= 1'b1;
        cyc(2);
        finish_test();
    end
    // Watchdog well beyond the expected run length
    initial begin
        cyc(5000);
        err_total++;
        finish_test();
    end
endmodule : tape_ctl_test
`default_nettype wire
